// >>> hdl/tacs_cmd.sv
// adjust/scan-path command interpreter with an AXI4-Lite slave port
// assumes a single 125 MHz clock and chip-side handshake on the ack bit of the chip control register
//
// What this block does
// - set-global-offset takes two written words: 11-bit coarse, then 5-bit fine.
// - read-global-offset supplies coarse word then fine word for reading.
// - while words remain, wait and refuse new opcodes.
// - set-channel-adjust: index in low byte, one word, low byte kept.
// - read-channel-adjust returns channel offset in low byte.
// - set-RC-adjust for chip n: one word, twelve low bits kept.
// - read-RC-adjust moves one word carrying the chip's 12-bit calibration.
// - save-RC-adjust asks chips to store calibration in EEPROM, no data.
// - read-chip-id returns one word with the chip identification code.
// - read-firmware-revision returns major/minor nibbles in low byte.
// - reset-PLL-and-DLL resets all chips' loops, no data words.
// - scan path kept as 16-bit word array; bit 639 is trigger matching.
// - parity over the scan path is computed by the device, not the host.
// - write-scan-word stores one word at index without loading chips.
// - read-scan-word returns the stored word at index; word 40 reads back with computed parity in bit 6.
// - load-scan-path shifts stored array into every chip.
// - reload-default loads the default array into every chip.
// - read-chip-errors returns 11 error bits of chip n.
// - read-lock returns chip n DLL lock in bit 0.
// - read-chip-status returns four words holding the 62-bit status.
// - per-chip load shifts stored array into chip n only.
`include "tacs_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module tacs_cmd (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic [3:0]  chip_req,
  output var  logic [3:0]  chip_cmd,
  output var  logic        trig_match
);
  // chip-facing status arrives through software-visible registers fed by chip firmware
  logic [31:0]       stat_lo_reg, stat_hi_reg, err01_reg, err23_reg;
  logic [3:0]        lock_reg;
  logic [`TACS_COARSE_W-1:0] coarse_reg;
  logic [`TACS_FINE_W-1:0]   fine_reg;
  logic [7:0]        cadj_reg [`TACS_CHANNELS];
  logic [`TACS_RC_W-1:0] rc_reg [`TACS_CHIPS];
  logic [15:0]       scan_reg [`TACS_SCAN_WORDS];
  tacs_pkg::tacs_state_t state_reg;
  logic [7:0]        op_reg, par_reg;
  logic [2:0]        left_reg, idx_reg;
  logic [15:0]       rd_word_reg;
  logic              parity_reg;
  logic              scan_par;
  logic              aw_hold, w_hold;
  logic [7:0]        aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic              wr_go, rd_go;
  logic              cmd_wr, data_wr, data_rd, busy;
  logic [1:0]        chip_sel;
  logic              scan_idx_ok;
  logic              ack_wr;

  assign wr_go   = aw_hold && w_hold && !s_axi_bvalid;
  assign rd_go   = s_axi_arvalid && s_axi_arready;
  assign busy    = state_reg != tacs_pkg::TACS_IDLE;
  assign cmd_wr  = wr_go && aw_addr_reg == `TACS_OFF_CMD && !busy;
  assign data_wr = wr_go && aw_addr_reg == `TACS_OFF_DATA && state_reg == tacs_pkg::TACS_WR;
  assign data_rd = rd_go && s_axi_araddr == `TACS_OFF_DATA && state_reg == tacs_pkg::TACS_RD;
  assign ack_wr  = wr_go && aw_addr_reg == `TACS_OFF_CHIPCTL && w_data_reg[`TACS_CC_ACK];
  assign chip_sel = par_reg[1:0];
  assign scan_idx_ok = par_reg <= `TACS_SCAN_LAST;

  // write address/data capture, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold     <= 1'b0;
      w_hold      <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold     <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end else if (wr_go) begin
        aw_hold <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold     <= 1'b1;
        w_data_reg <= s_axi_wdata;
      end else if (wr_go) begin
        w_hold <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !aw_hold && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_hold && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        case (aw_addr_reg)
          `TACS_OFF_CMD, `TACS_OFF_DATA, `TACS_OFF_CHIPCTL, `TACS_OFF_CHIPSTAT,
          `TACS_OFF_STAT_LO, `TACS_OFF_STAT_HI, `TACS_OFF_ERR01, `TACS_OFF_ERR23:
            s_axi_bresp <= (aw_addr_reg == `TACS_OFF_CMD && busy) ||
                           (aw_addr_reg == `TACS_OFF_DATA && state_reg != tacs_pkg::TACS_WR)
                           ? 2'b10 : 2'b00;
          default: s_axi_bresp <= 2'b10;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // opcode sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= tacs_pkg::TACS_IDLE;
      op_reg    <= 8'h00;
      par_reg   <= 8'h00;
      left_reg  <= 3'd0;
      idx_reg   <= 3'd0;
    end else begin
      unique case (state_reg)
        tacs_pkg::TACS_IDLE: begin
          if (cmd_wr) begin
            op_reg  <= w_data_reg[15:8];
            par_reg <= w_data_reg[7:0];
            idx_reg <= 3'd0;
            case (w_data_reg[15:8])
              tacs_pkg::TACS_OP_SET_GOFS: begin
                state_reg <= tacs_pkg::TACS_WR;
                left_reg  <= 3'd2;
              end
              tacs_pkg::TACS_OP_SET_CADJ, tacs_pkg::TACS_OP_SET_RC,
              tacs_pkg::TACS_OP_WR_SCAN: begin
                state_reg <= tacs_pkg::TACS_WR;
                left_reg  <= 3'd1;
              end
              tacs_pkg::TACS_OP_RD_GOFS: begin
                state_reg <= tacs_pkg::TACS_RD;
                left_reg  <= 3'd2;
              end
              tacs_pkg::TACS_OP_RD_STAT: begin
                state_reg <= tacs_pkg::TACS_RD;
                left_reg  <= 3'd4;
              end
              tacs_pkg::TACS_OP_RD_CADJ, tacs_pkg::TACS_OP_RD_RC, tacs_pkg::TACS_OP_RD_ID,
              tacs_pkg::TACS_OP_RD_FW, tacs_pkg::TACS_OP_RD_SCAN, tacs_pkg::TACS_OP_RD_ERR,
              tacs_pkg::TACS_OP_RD_LOCK: begin
                state_reg <= tacs_pkg::TACS_RD;
                left_reg  <= 3'd1;
              end
              tacs_pkg::TACS_OP_SAVE_RC, tacs_pkg::TACS_OP_PLL_RST, tacs_pkg::TACS_OP_LOAD,
              tacs_pkg::TACS_OP_DEFAULT, tacs_pkg::TACS_OP_LOAD_CHIP: begin
                state_reg <= tacs_pkg::TACS_CHIPW;
                left_reg  <= 3'd0;
              end
              default: state_reg <= tacs_pkg::TACS_IDLE;
            endcase
          end
        end
        tacs_pkg::TACS_WR, tacs_pkg::TACS_RD: begin
          if (data_wr || data_rd) begin
            idx_reg  <= idx_reg + 3'd1;
            left_reg <= left_reg - 3'd1;
            if (left_reg == 3'd1) begin
              state_reg <= tacs_pkg::TACS_IDLE;
            end
          end
        end
        tacs_pkg::TACS_CHIPW: begin
          if (ack_wr) begin
            state_reg <= tacs_pkg::TACS_IDLE;
          end
        end
      endcase
    end
  end

  // stored settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      coarse_reg <= '0;
      fine_reg   <= '0;
      for (int i = 0; i < `TACS_CHANNELS; i++) cadj_reg[i] <= 8'h00;
      for (int i = 0; i < `TACS_CHIPS; i++) rc_reg[i] <= `TACS_RC_RESET;
      for (int i = 0; i < `TACS_SCAN_WORDS; i++) scan_reg[i] <= `TACS_SCAN_DEFAULT;
    end else if (data_wr) begin
      case (op_reg)
        tacs_pkg::TACS_OP_SET_GOFS: begin
          if (idx_reg == 3'd0) coarse_reg <= w_data_reg[`TACS_COARSE_W-1:0];
          else fine_reg <= w_data_reg[`TACS_FINE_W-1:0];
        end
        tacs_pkg::TACS_OP_SET_CADJ:
          cadj_reg[par_reg[4:0]] <= w_data_reg[7:0];
        tacs_pkg::TACS_OP_SET_RC:
          rc_reg[chip_sel] <= w_data_reg[`TACS_RC_W-1:0];
        tacs_pkg::TACS_OP_WR_SCAN:
          if (scan_idx_ok) scan_reg[par_reg[5:0]] <= w_data_reg[15:0];
        default: ;
      endcase
    end
  end

  // chip-side status, written by the chip firmware over the same bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_lo_reg <= 32'h0000_0000;
      stat_hi_reg <= 32'h0000_0000;
      err01_reg   <= 32'h0000_0000;
      err23_reg   <= 32'h0000_0000;
      lock_reg    <= 4'h0;
    end else if (wr_go) begin
      case (aw_addr_reg)
        `TACS_OFF_CHIPSTAT: lock_reg    <= w_data_reg[3:0];
        `TACS_OFF_STAT_LO:  stat_lo_reg <= w_data_reg;
        `TACS_OFF_STAT_HI:  stat_hi_reg <= {2'b00, w_data_reg[29:0]};
        `TACS_OFF_ERR01:    err01_reg   <= w_data_reg;
        `TACS_OFF_ERR23:    err23_reg   <= w_data_reg;
        default: ;
      endcase
    end
  end

  // parity over the significant scan path bits, read back in word 40 bit 6
  always_comb begin
    scan_par = ^scan_reg[40][5:0];
    for (int i = 0; i < 40; i++) begin
      scan_par = scan_par ^ (^scan_reg[i]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      parity_reg <= 1'b0;
    end else begin
      parity_reg <= scan_par;
    end
  end

  // chip request lines; level until the chip firmware acknowledges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chip_req   <= 4'h0;
      chip_cmd   <= 4'h0;
      trig_match <= 1'b0;
    end else begin
      trig_match <= scan_reg[`TACS_TRIG_WORD][`TACS_TRIG_BIT];
      if (state_reg == tacs_pkg::TACS_CHIPW && !ack_wr) begin
        chip_cmd <= op_reg[3:0];
        chip_req <= (op_reg == tacs_pkg::TACS_OP_LOAD_CHIP) ?
                    4'(4'h1 << chip_sel) : 4'hf;
      end else begin
        chip_req <= 4'h0;
        chip_cmd <= 4'h0;
      end
    end
  end

  // word presented for the pending read
  always_comb begin
    rd_word_reg = 16'h0000;
    case (op_reg)
      tacs_pkg::TACS_OP_RD_GOFS:
        rd_word_reg = (idx_reg == 3'd0) ? {5'h00, coarse_reg} : {11'h000, fine_reg};
      tacs_pkg::TACS_OP_RD_CADJ: rd_word_reg = {8'h00, cadj_reg[par_reg[4:0]]};
      tacs_pkg::TACS_OP_RD_RC:   rd_word_reg = {4'h0, rc_reg[chip_sel]};
      tacs_pkg::TACS_OP_RD_ID:   rd_word_reg = `TACS_CHIP_ID;
      tacs_pkg::TACS_OP_RD_FW:   rd_word_reg = {8'h00, `TACS_FW_REV};
      tacs_pkg::TACS_OP_RD_SCAN:
        rd_word_reg = scan_idx_ok ?
                      (par_reg == `TACS_SCAN_LAST ?
                       {scan_reg[40][15:7], parity_reg, scan_reg[40][5:0]} :
                       scan_reg[par_reg[5:0]]) : 16'h0000;
      tacs_pkg::TACS_OP_RD_ERR:
        rd_word_reg = {5'h00, chip_sel[1] ?
                       (chip_sel[0] ? err23_reg[26:16] : err23_reg[10:0]) :
                       (chip_sel[0] ? err01_reg[26:16] : err01_reg[10:0])};
      tacs_pkg::TACS_OP_RD_LOCK: rd_word_reg = {15'h0000, lock_reg[chip_sel]};
      tacs_pkg::TACS_OP_RD_STAT:
        case (idx_reg[1:0])
          2'd0: rd_word_reg = stat_lo_reg[15:0];
          2'd1: rd_word_reg = stat_lo_reg[31:16];
          2'd2: rd_word_reg = stat_hi_reg[15:0];
          default: rd_word_reg = stat_hi_reg[31:16];
        endcase
      default: rd_word_reg = 16'h0000;
    endcase
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case ({s_axi_araddr[7:2], 2'b00})
          `TACS_OFF_DATA: begin
            s_axi_rdata <= {16'h0000, rd_word_reg};
            if (state_reg != tacs_pkg::TACS_RD) s_axi_rresp <= 2'b10;
          end
          `TACS_OFF_STATUS:
            s_axi_rdata <= {28'h0, state_reg == tacs_pkg::TACS_RD,
                            state_reg == tacs_pkg::TACS_RD, state_reg == tacs_pkg::TACS_WR, busy};
          `TACS_OFF_CMD:      s_axi_rdata <= {16'h0000, op_reg, par_reg};
          `TACS_OFF_CHIPCTL:  s_axi_rdata <= {24'h0, chip_req, chip_cmd};
          `TACS_OFF_CHIPSTAT: s_axi_rdata <= {28'h0, lock_reg};
          `TACS_OFF_STAT_LO:  s_axi_rdata <= stat_lo_reg;
          `TACS_OFF_STAT_HI:  s_axi_rdata <= stat_hi_reg;
          `TACS_OFF_ERR01:    s_axi_rdata <= err01_reg;
          `TACS_OFF_ERR23:    s_axi_rdata <= err23_reg;
          `TACS_OFF_IDREV:    s_axi_rdata <= {`TACS_CHIP_ID, 8'h00, `TACS_FW_REV};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  sequence s_cmd_two_writes;
    tacs_pkg::tacs_state_t'(state_reg) == tacs_pkg::TACS_WR && left_reg == 3'd2;
  endsequence
  a_gofs_two_words: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_wr && w_data_reg[15:8] == 8'h50 |=> s_cmd_two_writes)
    else $error("set global offset did not wait for two words");
  a_rdgofs_two: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_wr && w_data_reg[15:8] == 8'h51 |=> state_reg == tacs_pkg::TACS_RD && left_reg == 3'd2)
    else $error("read global offset did not offer two words");
  a_busy_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
    busy && wr_go && aw_addr_reg == `TACS_OFF_CMD |=> s_axi_bresp == 2'b10 && $stable(op_reg))
    else $error("opcode taken while busy");
  a_cadj_store: assert property (@(posedge aclk) disable iff (!aresetn)
    data_wr && op_reg == 8'h52 |=> cadj_reg[$past(par_reg[4:0])] == $past(w_data_reg[7:0]))
    else $error("channel adjust not stored");
  a_stat_four: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_wr && w_data_reg[15:8] == 8'h76 |=> left_reg == 3'd4)
    else $error("status read not four words");
  a_trig_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> trig_match == $past(scan_reg[39][15]))
    else $error("trigger match bit not followed");
  a_chip_only: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == tacs_pkg::TACS_CHIPW && op_reg == 8'h77 && !ack_wr
    |=> $onehot(chip_req))
    else $error("per-chip load reached several chips");
  a_lock_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    op_reg == 8'h75 |-> rd_word_reg[15:1] == 15'h0000)
    else $error("lock word has stray bits");
endmodule
`default_nettype wire

// >>> hdl/tacs_regs.svh
// register offsets, field positions, widths and reset values
// assumes inclusion by the interpreter, its package and the bench
`ifndef TACS_REGS_SVH
`define TACS_REGS_SVH
`define TACS_OFF_CMD       8'h00
`define TACS_OFF_DATA      8'h04
`define TACS_OFF_STATUS    8'h08
`define TACS_OFF_CHIPCTL   8'h0c
`define TACS_OFF_CHIPSTAT  8'h10
`define TACS_OFF_STAT_LO   8'h14
`define TACS_OFF_STAT_HI   8'h18
`define TACS_OFF_ERR01     8'h1c
`define TACS_OFF_ERR23     8'h20
`define TACS_OFF_IDREV     8'h24
`define TACS_ST_BUSY       0
`define TACS_ST_WR_WAIT    1
`define TACS_ST_RD_WAIT    2
`define TACS_ST_RD_AVAIL   3
`define TACS_CC_SAVE_RC    0
`define TACS_CC_PLL_RST    1
`define TACS_CC_LOAD       2
`define TACS_CC_DEFAULT    3
`define TACS_CC_CHIP_LSB   4
`define TACS_CC_ACK        8
`define TACS_COARSE_W      11
`define TACS_FINE_W        5
`define TACS_RC_W          12
`define TACS_ERR_W         11
`define TACS_SCAN_WORDS    41
`define TACS_SCAN_LAST     8'h28
`define TACS_TRIG_WORD     39
`define TACS_TRIG_BIT      15
`define TACS_CHANNELS      32
`define TACS_CHIPS         4
`define TACS_FW_REV        8'h13
`define TACS_CHIP_ID       16'h0a5c
`define TACS_RC_RESET      12'h000
`define TACS_SCAN_DEFAULT  16'h0000
`endif

// >>> hdl/tacs_pkg.sv
// types shared by the adjust/scan-path command interpreter
// assumes tacs_regs.svh for widths
`include "tacs_regs.svh"
package tacs_pkg;
  typedef enum logic [7:0] {
    TACS_OP_SET_GOFS  = 8'h50,
    TACS_OP_RD_GOFS   = 8'h51,
    TACS_OP_SET_CADJ  = 8'h52,
    TACS_OP_RD_CADJ   = 8'h53,
    TACS_OP_SET_RC    = 8'h54,
    TACS_OP_RD_RC     = 8'h55,
    TACS_OP_SAVE_RC   = 8'h56,
    TACS_OP_RD_ID     = 8'h60,
    TACS_OP_RD_FW     = 8'h61,
    TACS_OP_PLL_RST   = 8'h62,
    TACS_OP_WR_SCAN   = 8'h70,
    TACS_OP_RD_SCAN   = 8'h71,
    TACS_OP_LOAD      = 8'h72,
    TACS_OP_DEFAULT   = 8'h73,
    TACS_OP_RD_ERR    = 8'h74,
    TACS_OP_RD_LOCK   = 8'h75,
    TACS_OP_RD_STAT   = 8'h76,
    TACS_OP_LOAD_CHIP = 8'h77
  } tacs_op_t;
  typedef enum logic [1:0] {
    TACS_IDLE  = 2'b00,
    TACS_WR    = 2'b01,
    TACS_RD    = 2'b10,
    TACS_CHIPW = 2'b11
  } tacs_state_t;
endpackage

// >>> verif/tacs_host.sv
// host side of the register bus: an AXI4-Lite master driven through tasks
// assumes one clock; the bench calls wr and rd one at a time
`timescale 1ns/100ps
`default_nettype none
module tacs_host (
  input  wire logic        aclk,
  output var  logic [7:0]  awaddr,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var  logic        bready,
  output var  logic [7:0]  araddr,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // released payload shows the inverse, never the last value
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// >>> verif/tacs_cmd_test.sv
// self-checking bench for the adjust/scan-path command interpreter
// assumes tacs_host as bus master; the bench plays the chip firmware
`include "tacs_regs.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tacs_cmd_test;
  localparam logic [15:0] OPS [5] = '{16'h5600, 16'h6200, 16'h7200, 16'h7300, 16'h7702};
  localparam logic [3:0]  REQS [5] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'h4};
  localparam logic [10:0] ERRS [4] = '{11'h123, 11'h2bc, 11'h666, 11'h555};
  localparam logic [15:0] STW [4] = '{16'hcdef, 16'h89ab, 16'h3210, 16'h3fff};
  localparam logic [3:0]  LOCKS = 4'b0110;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdv;
  logic [3:0]  wstrb, chip_req, chip_cmd;
  logic [1:0]  bresp, rresp, rsp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, trig_match;
  int          bad_count = 0;
  int          total_checks = 0;
  always #4 aclk = ~aclk;
  tacs_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  tacs_cmd dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .chip_req(chip_req), .chip_cmd(chip_cmd),
    .trig_match(trig_match));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.wr(a, d, rsp);
  endtask
  task automatic rd(input logic [7:0] a);
    host.rd(a, rdv, rsp);
  endtask
  task automatic op(input logic [15:0] c);
    wr(`TACS_OFF_CMD, {16'h0000, c});
  endtask
  task automatic idle_chk();
    rd(`TACS_OFF_STATUS);
    `CHK(rdv[3:0], 4'h0)
  endtask
  task automatic t_reset();
    `CHK(chip_req, 4'h0)
    `CHK(trig_match, 1'b0)
    idle_chk();
  endtask
  task automatic t_gofs();
    op(16'h50a7);
    rd(`TACS_OFF_STATUS);
    `CHK(rdv[2:1], 2'b01)
    op(16'h6100);
    `CHK(rsp, 2'b10)
    wr(`TACS_OFF_DATA, 32'h0000_fd5a);
    rd(`TACS_OFF_STATUS);
    `CHK(rdv[2:1], 2'b01)
    wr(`TACS_OFF_DATA, 32'h0000_ffe9);
    idle_chk();
    wr(`TACS_OFF_DATA, 32'h0000_1111);
    `CHK(rsp, 2'b10)
    op(16'h5100);
    rd(`TACS_OFF_DATA);
    `CHK(rdv[15:0], 16'h055a)
    rd(`TACS_OFF_DATA);
    `CHK(rdv[15:0], 16'h0009)
    idle_chk();
  endtask
  task automatic t_adjust();
    for (int i = 0; i < 2; i++) begin
      op({8'h52, 8'(i * 31)});
      wr(`TACS_OFF_DATA, {16'h0000, 8'hc3, 8'(i * 31 + 1)});
    end
    for (int n = 0; n < 4; n++) begin
      op({8'h54, 8'(n)});
      wr(`TACS_OFF_DATA, {16'h0000, 4'hf, 12'(12'h111 * (n + 1))});
    end
    for (int i = 0; i < 2; i++) begin
      op({8'h53, 8'(i * 31)});
      rd(`TACS_OFF_DATA);
      `CHK(rdv[7:0], 8'(i * 31 + 1))
    end
    for (int n = 0; n < 4; n++) begin
      op({8'h55, 8'(n)});
      rd(`TACS_OFF_DATA);
      `CHK(rdv[11:0], 12'(12'h111 * (n + 1)))
    end
  endtask
  task automatic t_scan();
    op(16'h7027);
    wr(`TACS_OFF_DATA, 32'h0000_8000);
    `CHK(trig_match, 1'b1)
    `CHK(chip_req, 4'h0)
    op(16'h7000);
    wr(`TACS_OFF_DATA, 32'h0000_1234);
    op(16'h7100);
    rd(`TACS_OFF_DATA);
    `CHK(rdv[15:0], 16'h1234)
    op(16'h7127);
    rd(`TACS_OFF_DATA);
    `CHK(rdv[15:0], 16'h8000)
    op(16'h7027);
    wr(`TACS_OFF_DATA, 32'h0000_0000);
    `CHK(trig_match, 1'b0)
    op(16'h7028);
    wr(`TACS_OFF_DATA, 32'h0000_0003);
    op(16'h7128);
    rd(`TACS_OFF_DATA);
    `CHK(rdv[15:0], 16'h0043)
  endtask
  task automatic t_chip_ops();
    for (int i = 0; i < 5; i++) begin
      op(OPS[i]);
      `CHK(chip_req, REQS[i])
      `CHK(chip_cmd, OPS[i][11:8])
      op(16'h6100);
      `CHK(rsp, 2'b10)
      wr(`TACS_OFF_CHIPCTL, 32'h0000_0100);
      `CHK(chip_req, 4'h0)
      idle_chk();
    end
  endtask
  task automatic t_chip_reads();
    wr(`TACS_OFF_ERR01, 32'hfabc_f123);
    wr(`TACS_OFF_ERR23, 32'h0555_0666);
    wr(`TACS_OFF_CHIPSTAT, {28'h0, LOCKS});
    wr(`TACS_OFF_STAT_LO, 32'h89ab_cdef);
    wr(`TACS_OFF_STAT_HI, 32'hffff_3210);
    for (int n = 0; n < 4; n++) begin
      op({8'h74, 8'(n)});
      rd(`TACS_OFF_DATA);
      `CHK(rdv[10:0], ERRS[n])
      op({8'h75, 8'(n)});
      rd(`TACS_OFF_DATA);
      `CHK(rdv[0], LOCKS[n])
    end
    op(16'h7603);
    for (int i = 0; i < 4; i++) begin
      rd(`TACS_OFF_DATA);
      `CHK(rdv[15:0], STW[i])
    end
    idle_chk();
    op(16'h6001);
    rd(`TACS_OFF_DATA);
    `CHK(rdv[15:0], `TACS_CHIP_ID)
    op(16'h61ff);
    rd(`TACS_OFF_DATA);
    `CHK(rdv[7:0], `TACS_FW_REV)
  endtask
  task automatic t_refusals();
    rd(8'h30);
    `CHK(rsp, 2'b10)
    rd(`TACS_OFF_DATA);
    `CHK(rsp, 2'b10)
    op(16'h9955);
    `CHK(rsp, 2'b00)
    idle_chk();
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (25000) @(posedge aclk);
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_gofs();
    t_adjust();
    t_scan();
    t_chip_ops();
    t_chip_reads();
    t_refusals();
    end_sim();
  end
endmodule
`default_nettype wire
